/* File: src/agc_pkg.sv */
// Package for the gain calibration coefficient block: map, fields, timing, types.
// Assumes a 250 MHz pclk and a 32-bit APB with byte addresses.
package agc_pkg;

	// Register byte addresses
	localparam logic [31:0] CUR_GAIN_ADDR  = 32'hFFFF053C;
	localparam logic [31:0] VOLT_GAIN_ADDR = 32'hFFFF0540;
	localparam logic [31:0] TEMP_GAIN_ADDR = 32'hFFFF0544;
	localparam logic [31:0] MODE_ADDR      = 32'hFFFF05F0;
	localparam logic [31:0] STAT_ADDR      = 32'hFFFF05F4;

	// Mode register fields
	localparam int MODE_EN_BIT = 0;
	localparam int MODE_LO     = 1;
	localparam int MODE_HI     = 2;
	localparam int CHAN_LO     = 3;
	localparam int CHAN_HI     = 4;

	// Status register fields
	localparam int STAT_SETTLED_BIT = 0;
	localparam int STAT_CAL_BIT     = 1;
	localparam int STAT_REFUSED_BIT = 2;

	// Reset values (coefficients are replaced by factory trim right after release)
	localparam logic [15:0] GAIN_RST = 16'h0000;

	// Idle settling time before coefficient writes
	localparam int IDLE_MIN_NS  = 23000;
	localparam int PCLK_MHZ     = 250;
	localparam int IDLE_MIN_CYC = (IDLE_MIN_NS * PCLK_MHZ + 999) / 1000;

	// Coefficient format: unsigned 1.15, 16'h8000 is unity
	localparam int GAIN_W    = 16;
	localparam int GAIN_FRAC = 15;

	typedef enum logic [1:0] {agc_idle, agc_convert, agc_gaincal, agc_spare} agc_mode_t;
	typedef enum logic [1:0] {agc_ch_cur, agc_ch_volt, agc_ch_temp, agc_ch_none} agc_chan_t;

	// Picks the coefficient that belongs to a channel
	function automatic logic [15:0] agc_gain_of(input agc_chan_t ch, input logic [15:0] g0,
		input logic [15:0] g1, input logic [15:0] g2);
		unique case (ch)
			agc_ch_cur:  agc_gain_of = g0;
			agc_ch_volt: agc_gain_of = g1;
			agc_ch_temp: agc_gain_of = g2;
			agc_ch_none: agc_gain_of = 16'h0000;
		endcase
	endfunction : agc_gain_of

endpackage : agc_pkg

/* File: src/agc_scaler.sv */
// Multiplies a signed conversion result by an unsigned 1.15 gain, saturating.
// Assumes result and gain arrive in the pclk domain; one cycle of latency.
`timescale 1ns/1ps
module agc_scaler #(
	parameter int W    = agc_pkg::GAIN_W,
	parameter int FRAC = agc_pkg::GAIN_FRAC
) (
	// Clock, reset, freeze
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	// Raw result and gain in
	input  wire logic                in_valid,
	input  wire logic signed [W-1:0] in_data,
	input  wire logic        [W-1:0] gain,
	// Scaled result out
	output logic                     out_valid,
	output logic signed      [W-1:0] out_data
);
	import agc_pkg::*;

	logic signed [2*W:0] product;
	logic signed [2*W:0] shifted;

	// Clamps to the signed range instead of wrapping, since a gain above unity can overflow
	function automatic logic signed [W-1:0] sat(input logic signed [2*W:0] v);
		logic signed [2*W:0] hi;
		logic signed [2*W:0] lo;
		hi = (2*W+1)'((2**(W-1)) - 1);
		lo = -hi - (2*W+1)'(1);
		if (v > hi) sat = hi[W-1:0];
		else if (v < lo) sat = lo[W-1:0];
		else sat = v[W-1:0];
	endfunction : sat

	assign product = (2*W+1)'(in_data) * $signed({1'b0, gain});
	assign shifted = product >>> FRAC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (ce) begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_data <= sat(shifted);
			end
		end
	end

endmodule : agc_scaler

/* File: src/agc_regs.sv */
// Gain calibration coefficients of a three-channel converter, APB slave, result scaling.
// Assumes factory trim, calibration engine and raw results come from pclk-domain logic.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module agc_regs #(
	parameter int IDLE_CYCLES = agc_pkg::IDLE_MIN_CYC
) (
	// Clock, reset, freeze
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Factory trim
	input  wire logic [15:0]       factory_cur,
	input  wire logic [15:0]       factory_volt,
	input  wire logic [15:0]       factory_temp,
	// Calibration engine
	output logic                   cal_start,
	output agc_pkg::agc_chan_t     cal_chan,
	input  wire logic              cal_done,
	input  wire logic [15:0]       cal_value,
	// Converter control
	output logic                   conv_enable,
	output agc_pkg::agc_mode_t     conv_mode,
	// Raw results in
	input  wire logic              res_valid,
	input  wire agc_pkg::agc_chan_t res_chan,
	input  wire logic signed [15:0] res_data,
	// Scaled results out
	output logic                   scaled_valid,
	output agc_pkg::agc_chan_t     scaled_chan,
	output logic signed [15:0]     scaled_data
);
	import agc_pkg::*;

	logic [15:0] gain_cur;
	logic [15:0] gain_volt;
	logic [15:0] gain_temp;
	logic        trim_loaded;
	logic [15:0] idle_cnt;
	logic        idle_settled;
	logic        refused;
	logic        setup;
	logic        access;
	logic        wr_ok;
	logic        gain_hit;
	logic        mapped;
	logic        cal_load;
	logic [31:0] next_rdata;

	assign setup    = psel && !penable;
	assign access   = psel && penable && pready;
	assign wr_ok    = conv_enable && (conv_mode == agc_idle);
	assign gain_hit = (paddr == CUR_GAIN_ADDR) || (paddr == VOLT_GAIN_ADDR)
		|| (paddr == TEMP_GAIN_ADDR);
	assign mapped   = gain_hit || (paddr == MODE_ADDR) || (paddr == STAT_ADDR);
	assign cal_load = cal_done && (conv_mode == agc_gaincal);

	// Read data is registered in the setup cycle, so every access has one wait-free edge
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (paddr)
			CUR_GAIN_ADDR:  next_rdata[15:0] = gain_cur;
			VOLT_GAIN_ADDR: next_rdata[15:0] = gain_volt;
			TEMP_GAIN_ADDR: next_rdata[15:0] = gain_temp;
			MODE_ADDR: begin
				next_rdata[MODE_EN_BIT]     = conv_enable;
				next_rdata[MODE_HI:MODE_LO] = conv_mode;
				next_rdata[CHAN_HI:CHAN_LO] = cal_chan;
			end
			STAT_ADDR: begin
				next_rdata[STAT_SETTLED_BIT] = idle_settled;
				next_rdata[STAT_CAL_BIT]     = (conv_mode == agc_gaincal);
				next_rdata[STAT_REFUSED_BIT] = refused;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// APB answer: pready one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready <= setup;
			if (setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= !mapped || (pwrite && gain_hit && !wr_ok);
			end
		end
	end

	// Coefficients: trim after release, then calibration or accepted writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_loaded <= 1'b0;
			gain_cur    <= GAIN_RST;
			gain_volt   <= GAIN_RST;
			gain_temp   <= GAIN_RST;
		end else if (ce) begin
			if (!trim_loaded) begin
				trim_loaded <= 1'b1;
				gain_cur    <= factory_cur;
				gain_volt   <= factory_volt;
				gain_temp   <= factory_temp;
			end else if (cal_load) begin
				unique case (cal_chan)
					agc_ch_cur:  gain_cur  <= cal_value;
					agc_ch_volt: gain_volt <= cal_value;
					agc_ch_temp: gain_temp <= cal_value;
					agc_ch_none: gain_cur  <= gain_cur;
				endcase
			// pslverr was settled at setup; a calibration that ends mid-transfer
			// must not let a write that was already answered as refused land
			end else if (access && pwrite && wr_ok && !pslverr) begin
				if (paddr == CUR_GAIN_ADDR) gain_cur <= pwdata[15:0];
				if (paddr == VOLT_GAIN_ADDR) gain_volt <= pwdata[15:0];
				if (paddr == TEMP_GAIN_ADDR) gain_temp <= pwdata[15:0];
			end
		end
	end

	// Mode register; a finished calibration drops back to idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_enable <= 1'b0;
			conv_mode   <= agc_idle;
			cal_chan    <= agc_ch_cur;
			cal_start   <= 1'b0;
		end else if (ce) begin
			cal_start <= 1'b0;
			if (access && pwrite && paddr == MODE_ADDR) begin
				conv_enable <= pwdata[MODE_EN_BIT];
				conv_mode   <= agc_mode_t'(pwdata[MODE_HI:MODE_LO]);
				cal_chan    <= agc_chan_t'(pwdata[CHAN_HI:CHAN_LO]);
				cal_start   <= pwdata[MODE_EN_BIT]
					&& agc_mode_t'(pwdata[MODE_HI:MODE_LO]) == agc_gaincal;
			end else if (cal_load) begin
				conv_mode <= agc_idle;
			end
		end
	end

	// Settling timer only reports; software owns the wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= 16'h0000;
		end else if (ce) begin
			if (!wr_ok) idle_cnt <= 16'h0000;
			else if (!idle_settled) idle_cnt <= idle_cnt + 16'h0001;
		end
	end
	assign idle_settled = (idle_cnt == 16'(IDLE_CYCLES));

	// Sticky refused-write flag; a new refusal wins over the clear by a status read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused <= 1'b0;
		end else if (ce) begin
			if (access && pwrite && gain_hit && (pslverr || !wr_ok)) refused <= 1'b1;
			else if (access && !pwrite && paddr == STAT_ADDR) refused <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scaled_chan <= agc_ch_none;
		end else if (ce && res_valid) begin
			scaled_chan <= res_chan;
		end
	end

	agc_scaler #(
		.W    (GAIN_W),
		.FRAC (GAIN_FRAC)
	) u_scale (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.in_valid  (res_valid),
		.in_data   (res_data),
		.gain      (agc_gain_of(res_chan, gain_cur, gain_volt, gain_temp)),
		.out_valid (scaled_valid),
		.out_data  (scaled_data)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence wr_seq(logic [31:0] a);
		ce && trim_loaded && !cal_load && access && pwrite && paddr == a;
	endsequence

	cur_write_a: assert property (wr_seq(CUR_GAIN_ADDR) ##0 (wr_ok && !pslverr) |=>
		gain_cur == $past(pwdata[15:0])) else $error("current gain write lost");
	volt_write_a: assert property (wr_seq(VOLT_GAIN_ADDR) ##0 (wr_ok && !pslverr) |=>
		gain_volt == $past(pwdata[15:0])) else $error("voltage gain write lost");
	temp_write_a: assert property (wr_seq(TEMP_GAIN_ADDR) ##0 (wr_ok && !pslverr) |=>
		gain_temp == $past(pwdata[15:0])) else $error("temperature gain write lost");
	trim_load_a: assert property (ce && !trim_loaded |=> gain_cur == $past(factory_cur)
		&& gain_volt == $past(factory_volt) && gain_temp == $past(factory_temp))
		else $error("factory trim not loaded");
	cal_load_a: assert property (ce && trim_loaded && cal_load |=>
		agc_gain_of($past(cal_chan), gain_cur, gain_volt, gain_temp) == $past(cal_value)
		&& conv_mode == agc_idle) else $error("calibration result not stored");
	write_guard_a: assert property (ce && access && pwrite && gain_hit && !wr_ok
		&& !cal_load |=> $stable(gain_cur) && $stable(gain_volt) && $stable(gain_temp)
		&& refused) else $error("coefficient written outside idle");
	err_no_write_a: assert property (ce && access && pwrite && gain_hit && pslverr
		&& trim_loaded && !cal_load |=> $stable(gain_cur) && $stable(gain_volt)
		&& $stable(gain_temp)) else $error("write answered with error still landed");
	settle_time_a: assert property (ce && wr_ok && idle_cnt == 16'h0000 ##1 (ce && wr_ok)[*2]
		|-> !idle_settled) else $error("settled reported too early");
	refuse_err_a: assert property (ce && setup && pwrite && gain_hit && !wr_ok
		|=> pready && pslverr) else $error("refused write not flagged");
	scale_lat_a: assert property (ce && res_valid |=> scaled_valid
		&& scaled_chan == $past(res_chan)) else $error("scaled result missing");

endmodule : agc_regs

/* File: sim/tb.sv */
// Self-checking bench for the gain coefficient block: APB access, trim, gating, scaling, cal.
// Assumes agc_pkg and agc_regs are compiled first; the bench checks values itself, and the design files add assertions.
`timescale 1ns/1ps
module tb;
	import agc_pkg::*;
	// Shortened settle time so the run stays short
	localparam int IDLE = 8;
	logic              pclk, presetn, ce, psel, penable, pwrite, cal_done, res_valid;
	logic [31:0]       paddr, pwdata, prdata;
	logic              pready, pslverr, cal_start, conv_enable, scaled_valid;
	logic [15:0]       factory_cur, factory_volt, factory_temp, cal_value;
	logic signed [15:0] res_data, scaled_data;
	agc_chan_t         cal_chan, res_chan, scaled_chan;
	agc_mode_t         conv_mode;
	int                n_fail, samples_checked;
	logic [31:0]       rd;
	logic              er;
	logic [31:0]       gadr [3] = '{CUR_GAIN_ADDR, VOLT_GAIN_ADDR, TEMP_GAIN_ADDR};

	agc_regs #(.IDLE_CYCLES(IDLE)) agc_regs_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .factory_cur(factory_cur),
		.factory_volt(factory_volt), .factory_temp(factory_temp), .cal_start(cal_start),
		.cal_chan(cal_chan), .cal_done(cal_done), .cal_value(cal_value),
		.conv_enable(conv_enable), .conv_mode(conv_mode), .res_valid(res_valid),
		.res_chan(res_chan), .res_data(res_data), .scaled_valid(scaled_valid),
		.scaled_chan(scaled_chan), .scaled_data(scaled_data));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic final_report;
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	// One APB transfer; pready, prdata and pslverr are taken at the rising edge that ends it
	task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		bit got;
		got = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 20 && !got; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				r = prdata; e = pslverr; got = 1;
			end
		end
		if (!got) begin
			n_fail++;
			final_report();
		end
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// Signed result times unsigned 1.15 gain, saturated to 16 bits
	function automatic logic [15:0] scale(input logic signed [15:0] r, input logic [15:0] g);
		logic signed [33:0] p;
		p = (r * $signed({1'b0, g})) >>> 15;
		if (p > 34'sd32767) return 16'h7FFF;
		if (p < -34'sd32768) return 16'h8000;
		return p[15:0];
	endfunction : scale

	task automatic t_trim;
		chk({conv_enable, conv_mode}, 3'h0, "reset mode");
		apb(CUR_GAIN_ADDR, 0, 0, rd, er);  chk(rd, {16'h0, factory_cur}, "trim cur");
		apb(VOLT_GAIN_ADDR, 0, 0, rd, er); chk(rd, {16'h0, factory_volt}, "trim volt");
		apb(TEMP_GAIN_ADDR, 0, 0, rd, er); chk(rd, {16'h0, factory_temp}, "trim temp");
		apb(32'hFFFF0548, 0, 0, rd, er);   chk({er, rd}, 33'h1_0000_0000, "unmapped");
		$display("test trim done");
	endtask : t_trim

	task automatic t_refuse;
		apb(CUR_GAIN_ADDR, 1, 32'h1111, rd, er); chk(er, 1'b1, "disabled write err");
		apb(CUR_GAIN_ADDR, 0, 0, rd, er); chk(rd, {16'h0, factory_cur}, "kept");
		apb(MODE_ADDR, 1, 32'h3, rd, er);
		apb(VOLT_GAIN_ADDR, 1, 32'h2222, rd, er); chk(er, 1'b1, "convert write err");
		apb(VOLT_GAIN_ADDR, 0, 0, rd, er); chk(rd, {16'h0, factory_volt}, "kept");
		apb(STAT_ADDR, 0, 0, rd, er); chk(rd[STAT_REFUSED_BIT], 1'b1, "refused flag");
		$display("test refuse done");
	endtask : t_refuse

	task automatic t_write;
		logic [31:0] wd [3] = '{32'hFFFF8000, 32'h00004000, 32'hA5A5FFFF};
		apb(MODE_ADDR, 1, 32'h1, rd, er);
		apb(STAT_ADDR, 0, 0, rd, er); chk(rd[2:0], 3'h0, "not settled yet");
		repeat (IDLE + 2) @(posedge pclk);
		apb(STAT_ADDR, 0, 0, rd, er); chk(rd[2:0], 3'h1, "settled");
		for (int i = 0; i < 3; i++) begin
			apb(gadr[i], 1, wd[i], rd, er); chk(er, 1'b0, "idle write ok");
			apb(gadr[i], 0, 0, rd, er); chk(rd, {16'h0, wd[i][15:0]}, "readback");
		end
		$display("test write done");
	endtask : t_write

	task automatic t_scale(input agc_chan_t ch, input logic [15:0] r, input logic [15:0] g);
		@(posedge pclk);
		res_valid <= 1'b1; res_chan <= ch; res_data <= r;
		@(posedge pclk);
		res_valid <= 1'b0; res_chan <= agc_ch_none; res_data <= ~r;
		@(negedge pclk);
		chk({scaled_valid, scaled_chan, scaled_data}, {1'b1, ch, scale(r, g)}, "scaled");
	endtask : t_scale

	task automatic t_cal;
		bit seen;
		seen = 0;
		apb(MODE_ADDR, 1, 32'hD, rd, er);
		for (int i = 0; i < 4 && !seen; i++) begin
			@(negedge pclk);
			seen = (cal_start === 1'b1);
		end
		chk({seen, cal_chan}, {1'b1, agc_ch_volt}, "cal start");
		apb(VOLT_GAIN_ADDR, 1, 32'h5555, rd, er); chk(er, 1'b1, "busy write err");
		@(posedge pclk);
		cal_done <= 1'b1; cal_value <= 16'h9ABC;
		@(posedge pclk);
		cal_done <= 1'b0; cal_value <= 16'h6543;
		@(negedge pclk);
		chk(conv_mode, agc_idle, "back to idle");
		apb(VOLT_GAIN_ADDR, 0, 0, rd, er); chk(rd, 32'h9ABC, "cal value");
		apb(CUR_GAIN_ADDR, 0, 0, rd, er); chk(rd, 32'h8000, "other chan kept");
		t_scale(agc_ch_volt, 16'h7000, 16'h9ABC);
		$display("test cal done");
	endtask : t_cal

	initial begin
		presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; cal_done = 1'b0; cal_value = '0; res_valid = 1'b0;
		res_chan = agc_ch_none; res_data = '0; n_fail = 0; samples_checked = 0;
		// Arbitrary trim values, distinct per channel
		factory_cur = 16'h7E21; factory_volt = 16'h8C44; factory_temp = 16'h9D17;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_trim();
		t_refuse();
		t_write();
		t_scale(agc_ch_cur, 16'h7000, 16'h8000);
		t_scale(agc_ch_volt, 16'h7000, 16'h4000);
		t_scale(agc_ch_temp, 16'h7000, 16'hFFFF);
		t_scale(agc_ch_temp, 16'h9000, 16'hFFFF);
		$display("test scale done");
		t_cal();
		final_report();
	end
endmodule : tb
